/* hw/vcd_decoder.sv */
// Contract
// - a command is start, address byte, one data byte, stop; nothing else acts
// - address accepted only when its top three bits equal 110; next bit ignored
// - address bit 3 selects core rail b; ignored in combined mode
// - address bit 2 selects core rail a, or the unified rail when combined
// - address bit 1 selects the bridge rail
// - indicator 0 puts selected rails in pulse skipping after boot mode
// - indicator 0 disables the output offset even when strapped on
// - indicator 0 in combined mode forces single-phase core operation
// - indicator 1 puts selected rails in forced PWM after boot mode
// - indicator 1 enables the output offset if the strap enabled it
// - indicator 1 in combined mode returns the core to two phases
// - low seven data bits are the voltage code for each selected rail
// - at cycle start, skip the on-time pulse while output is above threshold
// - start is data falling with clock high from idle; stop is data rising
// - acknowledge only on address match outside programming mode, low all high
`timescale 1ns/100ps
`default_nettype none

module vcd_decoder (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic vid_link_clock,
   input wire logic vid_link_data_in,
   output logic vid_link_data_out,
   output logic vid_link_data_oe,
   input wire logic remote_ground_sense_a,
   input wire logic remote_ground_sense_b,
   input wire logic boot_mode_active,
   input wire logic programming_mode,
   input wire logic offset_strap,
   input wire logic switch_cycle_start,
   input wire logic output_above_threshold,
   output vcd_pkg::vcd_rail_type core_a_rail,
   output vcd_pkg::vcd_rail_type core_b_rail,
   output vcd_pkg::vcd_rail_type bridge_rail,
   output logic core_a_pulse_skip,
   output logic core_b_pulse_skip,
   output logic bridge_pulse_skip,
   output logic offset_enable,
   output logic two_phase,
   output logic combined_mode,
   output logic command_strobe,
   output logic on_time_trigger
);
   import vcd_pkg::*;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic vcd_rail_type vcd_rail_update(
      input vcd_rail_type old_rail,
      input logic selected,
      input vcd_cmd_type cmd
   );
      vcd_rail_type new_rail;
      new_rail = old_rail;
      if (selected) begin
         new_rail.power_save_indicator_n = cmd.power_save_indicator_n;
         new_rail.voltage_id_code = cmd.voltage_id_code;
      end
      return new_rail;
   endfunction

   function automatic logic vcd_skip_mode(
      input vcd_rail_type rail,
      input logic boot
   );
      // during boot the rail keeps forced PWM; the indicator only acts after it
      return ~rail.power_save_indicator_n & ~boot;
   endfunction

   // ----------------------------------------
   // pin synchronisers, reference domain
   // ----------------------------------------
   // the top bit is a constant one; it reaches the far end once the other pins are valid
   localparam int PIN_COUNT = 9;
   logic [PIN_COUNT-1:0] pins_s;
   logic sync_full_s;
   logic scl_s;
   logic sda_s;
   logic gnd_a_s;
   logic gnd_b_s;
   logic boot_s;
   logic strap_s;
   logic cycle_s;
   logic above_s;

   vcd_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
      .clk(ref_clk),
      .rst(rst),
      .d({1'b1, vid_link_clock, vid_link_data_in, remote_ground_sense_a, remote_ground_sense_b,
          boot_mode_active, offset_strap, switch_cycle_start, output_above_threshold}),
      .q(pins_s)
   );

   assign {sync_full_s, scl_s, sda_s, gnd_a_s, gnd_b_s, boot_s, strap_s, cycle_s, above_s} = pins_s;

   // ----------------------------------------
   // frame tracking, reference domain
   // ----------------------------------------
   vcd_state_type state_reg;
   vcd_state_type state_next;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic link_hold_reg;
   logic pending_reg;
   logic pending_next;
   logic tog_prev_reg;
   logic tog_s;
   vcd_cmd_type cmd_reg;
   vcd_cmd_type word_reg;

   // a start is only honoured from an idle bus, so repeated starts are ignored
   wire start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   wire stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
   wire word_ready = tog_s ^ tog_prev_reg;
   wire commit = (state_reg == VCD_FRAME) & stop_det & pending_reg;

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         VCD_IDLE: begin
            if (start_det) begin
               state_next = VCD_FRAME;
            end
         end
         VCD_FRAME: begin
            if (stop_det) begin
               state_next = VCD_IDLE;
            end
         end
         default: begin
            state_next = VCD_IDLE;
         end
      endcase
   end

   always_comb begin
      pending_next = pending_reg;
      if (state_reg == VCD_IDLE) begin
         // a word seen outside a frame is stale and dropped
         pending_next = 1'b0;
      end else if (word_ready) begin
         pending_next = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_reg <= VCD_IDLE;
         scl_prev_reg <= 1'b0;
         sda_prev_reg <= 1'b0;
         pending_reg <= 1'b0;
         tog_prev_reg <= 1'b0;
         link_hold_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
         pending_reg <= pending_next;
         tog_prev_reg <= tog_s;
         // link logic stays cleared outside frames; the stop itself ends it
         link_hold_reg <= (state_next == VCD_IDLE);
      end
   end

   // word is written once per frame and long settled when the toggle lands
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmd_reg <= '0;
      end else if (word_ready) begin
         cmd_reg <= word_reg;
      end
   end

   // ----------------------------------------
   // link domain, bit capture
   // ----------------------------------------
   logic [4:0] bit_cnt_reg;
   logic [4:0] bit_cnt_next;
   logic [7:0] shift_reg;
   logic [7:0] shift_next;
   logic [2:0] sel_reg;
   logic addr_ok_reg;
   logic prog_link_s;
   logic tog_reg;

   vcd_sync #(.WIDTH(1)) u_prog_sync (
      .clk(vid_link_clock),
      .rst(rst),
      .d(programming_mode),
      .q(prog_link_s)
   );

   // data is sampled on the rising clock edge, stable through the high phase
   assign shift_next = {shift_reg[6:0], vid_link_data_in};
   assign bit_cnt_next = (bit_cnt_reg == VCD_CNT_DONE) ? bit_cnt_reg : bit_cnt_reg + 5'h01;

   // direction flag is not checked; the master only ever writes
   wire addr_match = (shift_next[VCD_ADDR_MSB:VCD_ADDR_LSB] == VCD_ADDR_PATTERN);
   wire addr_last = (bit_cnt_reg == VCD_CNT_ADDR_LAST);
   wire data_last = (bit_cnt_reg == VCD_CNT_DATA_LAST);
   wire in_byte = (bit_cnt_reg < VCD_CNT_ADDR_ACK) |
                  ((bit_cnt_reg > VCD_CNT_ADDR_ACK) & (bit_cnt_reg <= VCD_CNT_DATA_LAST));

   always_ff @(posedge vid_link_clock or posedge link_hold_reg) begin
      if (link_hold_reg) begin
         bit_cnt_reg <= 5'h00;
         shift_reg <= 8'h00;
         sel_reg <= 3'h0;
         addr_ok_reg <= 1'b0;
      end else begin
         bit_cnt_reg <= bit_cnt_next;
         if (in_byte) begin
            shift_reg <= shift_next;
         end
         if (addr_last) begin
            addr_ok_reg <= addr_match & ~prog_link_s;
            sel_reg <= {shift_next[VCD_SEL_CORE_B], shift_next[VCD_SEL_CORE_A],
                        shift_next[VCD_SEL_BRIDGE]};
         end
      end
   end

   // word and toggle survive the frame hold so the handoff is never torn
   always_ff @(posedge vid_link_clock or posedge rst) begin
      if (rst) begin
         word_reg <= '0;
         tog_reg <= 1'b0;
      end else if (data_last & addr_ok_reg & ~link_hold_reg) begin
         word_reg.rail_select <= sel_reg;
         word_reg.power_save_indicator_n <= shift_next[VCD_PSI_BIT];
         word_reg.voltage_id_code <= shift_next[VCD_CODE_MSB:0];
         tog_reg <= ~tog_reg;
      end
   end

   vcd_sync #(.WIDTH(1)) u_tog_sync (
      .clk(ref_clk),
      .rst(rst),
      .d(tog_reg),
      .q(tog_s)
   );

   // ----------------------------------------
   // link domain, acknowledge drive
   // ----------------------------------------
   logic ack_oe_reg;
   // the ninth clock of each byte belongs to the acknowledge
   wire ack_slot = (bit_cnt_reg == VCD_CNT_ADDR_ACK) | (bit_cnt_reg == VCD_CNT_DATA_ACK);

   // changed on the falling edge so the line is low for the whole high phase
   always_ff @(negedge vid_link_clock or posedge link_hold_reg) begin
      if (link_hold_reg) begin
         ack_oe_reg <= 1'b0;
      end else begin
         ack_oe_reg <= ack_slot & addr_ok_reg;
      end
   end

   assign vid_link_data_oe = ack_oe_reg;

   // only ever pulls low; the driven level is a constant zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         vid_link_data_out <= 1'b0;
      end else begin
         vid_link_data_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // command apply
   // ----------------------------------------
   logic strap_cap_reg;
   logic strap_done_reg;
   logic psi_reg;

   wire combined_w = gnd_a_s | gnd_b_s;
   // core b select is void once the rails are merged
   wire sel_core_b = cmd_reg.rail_select[2] & ~combined_mode;
   wire sel_core_a = cmd_reg.rail_select[1];
   wire sel_bridge = cmd_reg.rail_select[0];

   // strap is caught once, when the synchroniser holds a real pin value; a later change needs a reset
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strap_cap_reg <= 1'b0;
         strap_done_reg <= 1'b0;
      end else if (~strap_done_reg & sync_full_s) begin
         strap_cap_reg <= strap_s;
         strap_done_reg <= 1'b1;
      end
   end

   // all selected rails load in the same cycle from one data byte
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         core_a_rail <= '{VCD_PSI_RESET, VCD_CODE_RESET};
         core_b_rail <= '{VCD_PSI_RESET, VCD_CODE_RESET};
         bridge_rail <= '{VCD_PSI_RESET, VCD_CODE_RESET};
         psi_reg <= VCD_PSI_RESET;
      end else if (commit) begin
         core_a_rail <= vcd_rail_update(core_a_rail, sel_core_a, cmd_reg);
         core_b_rail <= vcd_rail_update(core_b_rail, sel_core_b, cmd_reg);
         bridge_rail <= vcd_rail_update(bridge_rail, sel_bridge, cmd_reg);
         psi_reg <= cmd_reg.power_save_indicator_n;
      end
   end

   // ----------------------------------------
   // mode outputs
   // ----------------------------------------
   wire offset_next = strap_cap_reg & psi_reg;
   wire two_phase_next = ~combined_w | psi_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         core_a_pulse_skip <= 1'b0;
         core_b_pulse_skip <= 1'b0;
         bridge_pulse_skip <= 1'b0;
         offset_enable <= 1'b0;
         two_phase <= 1'b1;
         combined_mode <= 1'b0;
         command_strobe <= 1'b0;
      end else begin
         core_a_pulse_skip <= vcd_skip_mode(core_a_rail, boot_s);
         core_b_pulse_skip <= vcd_skip_mode(core_b_rail, boot_s);
         bridge_pulse_skip <= vcd_skip_mode(bridge_rail, boot_s);
         offset_enable <= offset_next;
         two_phase <= two_phase_next;
         combined_mode <= combined_w;
         command_strobe <= commit;
      end
   end

   // ----------------------------------------
   // pulse skip gate at switching cycle start
   // ----------------------------------------
   vcd_skip_gate u_skip (
      .ref_clk(ref_clk),
      .rst(rst),
      .cycle_start_s(cycle_s),
      .above_threshold_s(above_s),
      .on_time_trigger(on_time_trigger)
   );

endmodule

`default_nettype wire

/* include/vcd_pkg.sv */
package vcd_pkg;

   // ----------------------------------------
   // address byte layout, bit 0 is the direction flag
   // ----------------------------------------
   localparam logic [2:0] VCD_ADDR_PATTERN = 3'h6;
   localparam int VCD_ADDR_MSB = 7;
   localparam int VCD_ADDR_LSB = 5;
   localparam int VCD_SEL_CORE_B = 3;
   localparam int VCD_SEL_CORE_A = 2;
   localparam int VCD_SEL_BRIDGE = 1;
   localparam int VCD_DIR_BIT = 0;

   // ----------------------------------------
   // data byte layout
   // ----------------------------------------
   localparam int VCD_PSI_BIT = 7;
   localparam int VCD_CODE_MSB = 6;

   // ----------------------------------------
   // link bit counter, counted on rising link clock edges
   // ----------------------------------------
   localparam logic [4:0] VCD_CNT_ADDR_LAST = 5'h07;
   localparam logic [4:0] VCD_CNT_ADDR_ACK = 5'h08;
   localparam logic [4:0] VCD_CNT_DATA_LAST = 5'h10;
   localparam logic [4:0] VCD_CNT_DATA_ACK = 5'h11;
   localparam logic [4:0] VCD_CNT_DONE = 5'h12;

   // ----------------------------------------
   // values after reset
   // ----------------------------------------
   localparam logic [6:0] VCD_CODE_RESET = 7'h00;
   localparam logic VCD_PSI_RESET = 1'b1;

   typedef struct packed {
      logic [2:0] rail_select;
      logic power_save_indicator_n;
      logic [6:0] voltage_id_code;
   } vcd_cmd_type;

   typedef struct packed {
      logic power_save_indicator_n;
      logic [6:0] voltage_id_code;
   } vcd_rail_type;

   typedef enum logic [0:0] {
      VCD_IDLE,
      VCD_FRAME
   } vcd_state_type;

endpackage

/* hw/vcd_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module vcd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   // ----------------------------------------
   // two flops; the first one feeds nothing but the second
   // ----------------------------------------
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end

endmodule

`default_nettype wire

/* hw/vcd_skip_gate.sv */
`timescale 1ns/100ps
`default_nettype none

module vcd_skip_gate (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cycle_start_s,
   input wire logic above_threshold_s,
   output logic on_time_trigger
);
   // ----------------------------------------
   // on-time launch at each switching cycle start
   // ----------------------------------------
   logic cycle_prev_reg;
   wire cycle_edge = cycle_start_s & ~cycle_prev_reg;
   // skip wins over the selected mode while the output is still high
   wire trigger_next = cycle_edge & ~above_threshold_s;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cycle_prev_reg <= 1'b0;
         on_time_trigger <= 1'b0;
      end else begin
         cycle_prev_reg <= cycle_start_s;
         on_time_trigger <= trigger_next;
      end
   end

endmodule

`default_nettype wire

/* testbench/vcd_decoder_properties.sv */
`timescale 1ns/100ps
`default_nettype none

module vcd_decoder_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic vid_link_clock,
   input wire logic vid_link_data_in,
   input wire logic vid_link_data_out,
   input wire logic vid_link_data_oe,
   input wire logic programming_mode,
   input wire logic offset_strap,
   input wire logic output_above_threshold,
   input wire vcd_pkg::vcd_rail_type core_a_rail,
   input wire vcd_pkg::vcd_rail_type core_b_rail,
   input wire vcd_pkg::vcd_rail_type bridge_rail,
   input wire logic core_a_pulse_skip,
   input wire logic bridge_pulse_skip,
   input wire logic offset_enable,
   input wire logic two_phase,
   input wire logic combined_mode,
   input wire logic command_strobe,
   input wire logic on_time_trigger
);
   import vcd_pkg::*;
   // ----
   // properties
   // ----
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   strobe_idle_a: assert property (command_strobe |-> vid_link_clock && vid_link_data_in ##1 !command_strobe)
      else $error("strobe outside idle bus");
   rail_hold_a: assert property ($changed(core_a_rail) || $changed(bridge_rail) |->
      command_strobe || $past(command_strobe)) else $error("rail moved without command");
   core_b_comb_a: assert property (combined_mode && $past(combined_mode) |-> $stable(core_b_rail))
      else $error("core b written in combined mode");
   skip_low_a: assert property (core_a_pulse_skip |-> !$past(core_a_rail.power_save_indicator_n))
      else $error("pulse skip with indicator high");
   pwm_high_a: assert property (bridge_rail.power_save_indicator_n && $past(bridge_rail.power_save_indicator_n)
      |-> !bridge_pulse_skip) else $error("no forced pwm with indicator high");
   offset_strap_a: assert property (offset_enable |-> offset_strap)
      else $error("offset without strap");
   phase_comb_a: assert property (!two_phase |-> combined_mode)
      else $error("single phase outside combined mode");
   ack_drive_a: assert property ($changed(vid_link_data_oe) |-> !vid_link_clock)
      else $error("acknowledge moved while link clock high");
   ack_value_a: assert property ($rose(vid_link_data_oe) |-> !vid_link_data_out && !programming_mode)
      else $error("bad acknowledge drive");
   trig_once_a: assert property (on_time_trigger |-> !$past(output_above_threshold, 3) ##1 !on_time_trigger)
      else $error("on time pulse while above threshold");

   strobe_c: cover property (command_strobe);
   ack_c: cover property ($rose(vid_link_data_oe));
   trig_c: cover property (on_time_trigger);
endmodule

bind vcd_decoder vcd_decoder_checker u_vcd_decoder_checker (.ref_clk, .rst, .vid_link_clock, .vid_link_data_in,
   .vid_link_data_out, .vid_link_data_oe, .programming_mode, .offset_strap, .output_above_threshold,
   .core_a_rail, .core_b_rail, .bridge_rail, .core_a_pulse_skip, .bridge_pulse_skip, .offset_enable,
   .two_phase, .combined_mode, .command_strobe, .on_time_trigger);

`default_nettype wire

/* testbench/vcd_link_master.sv */
`timescale 1ns/100ps
`default_nettype none

// ----
// processor side of the link, write only
// ----
module vcd_link_master (
   output logic link_clock,
   output logic data_drive,
   output logic data_en,
   input wire logic data_wire
);
   // clock stands high between frames
   initial begin
      link_clock = 1'b1;
      data_drive = 1'b1;
      data_en = 1'b1;
   end

   task automatic frame(input logic [7:0] addr, input logic [7:0] data, input int clocks, output logic ack);
      logic [17:0] bits;
      bits = {addr[7:1], 1'b1, 1'b1, data, 1'b1};
      ack = 1'b0;
      data_drive = 1'b0;
      #62.5;
      link_clock = 1'b0;
      for (int k = 0; k < clocks; k++) begin
         #31;
         data_en = !(k == 8 || k == 17);
         data_drive = bits[17-k];
         #31.5;
         link_clock = 1'b1;
         #31;
         // a full frame needs both bytes acknowledged; a cut one only the address
         if (k == 8 || k == 17) begin
            ack = (k == 8 || ack) && !data_wire;
         end
         #31.5;
         link_clock = 1'b0;
      end
      #31;
      data_en = 1'b1;
      data_drive = 1'b0;
      #31.5;
      link_clock = 1'b1;
      #62.5;
      data_drive = 1'b1;
      #500;
   endtask
endmodule

`default_nettype wire

/* testbench/tb_vcd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_vcd_decoder;
   import vcd_pkg::*;
   // ----
   // signals
   // ----
   logic ref_clk, rst, vid_link_clock, vid_link_data_in, vid_link_data_out, vid_link_data_oe, m_d, m_en;
   logic remote_ground_sense_a, remote_ground_sense_b, boot_mode_active, programming_mode, offset_strap;
   logic switch_cycle_start, output_above_threshold, core_a_pulse_skip, core_b_pulse_skip, bridge_pulse_skip;
   logic offset_enable, two_phase, combined_mode, command_strobe, on_time_trigger, ack, last_psi;
   vcd_rail_type core_a_rail, core_b_rail, bridge_rail;
   logic [1:0] gnd;
   logic [7:0] e_a, e_b, e_n;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int trig_seen;
   int strobes = 0;

`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end

   // pull-up on the data line: a released line reads high
   assign vid_link_data_in = vid_link_data_oe ? vid_link_data_out : (m_en ? m_d : 1'b1);
   assign remote_ground_sense_a = gnd[1];
   assign remote_ground_sense_b = gnd[0];

   vcd_decoder u_vcd_decoder (.ref_clk, .rst, .vid_link_clock, .vid_link_data_in, .vid_link_data_out,
      .vid_link_data_oe, .remote_ground_sense_a, .remote_ground_sense_b, .boot_mode_active, .programming_mode,
      .offset_strap, .switch_cycle_start, .output_above_threshold, .core_a_rail, .core_b_rail, .bridge_rail,
      .core_a_pulse_skip, .core_b_pulse_skip, .bridge_pulse_skip, .offset_enable, .two_phase, .combined_mode,
      .command_strobe, .on_time_trigger);

   vcd_link_master u_vcd_link_master (.link_clock(vid_link_clock), .data_drive(m_d), .data_en(m_en),
      .data_wire(vid_link_data_in));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   always @(negedge ref_clk) begin
      if (command_strobe !== 1'b0) strobes++;
   end

   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----
   // one command frame, then every rail and mode output against the expected state
   // ----
   task step(input logic [7:0] a, input logic [7:0] d, input int clocks, input logic [1:0] g, input logic p,
      input logic b);
      logic hit;
      @(negedge ref_clk);
      gnd = g;
      programming_mode = p;
      boot_mode_active = b;
      strobes = 0;
      repeat (10) @(negedge ref_clk);
      u_vcd_link_master.frame(a, d, clocks, ack);
      hit = (a[VCD_ADDR_MSB:VCD_ADDR_LSB] == VCD_ADDR_PATTERN) && !p;
      `CHK("address ack", hit, ack)
      if (hit && clocks == 18) begin
         if (a[VCD_SEL_CORE_B] && g == 2'h0) e_b = d;
         if (a[VCD_SEL_CORE_A]) e_a = d;
         if (a[VCD_SEL_BRIDGE]) e_n = d;
         last_psi = d[VCD_PSI_BIT];
      end
      repeat (20) @(negedge ref_clk);
      `CHK("core a", e_a, core_a_rail)
      `CHK("core b", e_b, core_b_rail)
      `CHK("bridge", e_n, bridge_rail)
      `CHK("skip a", !e_a[VCD_PSI_BIT] && !b, core_a_pulse_skip)
      `CHK("skip b", !e_b[VCD_PSI_BIT] && !b, core_b_pulse_skip)
      `CHK("skip n", !e_n[VCD_PSI_BIT] && !b, bridge_pulse_skip)
      `CHK("offset", offset_strap && last_psi, offset_enable)
      `CHK("two phase", g == 2'h0 || last_psi, two_phase)
      `CHK("combined", |g, combined_mode)
      `CHK("strobes", (hit && clocks == 18) ? 1 : 0, strobes)
   endtask

   // ----
   // switching cycle start with the output above or below threshold
   // ----
   task cycle_check(input logic hi);
      @(negedge ref_clk);
      output_above_threshold = hi;
      repeat (8) @(negedge ref_clk);
      switch_cycle_start = 1'b1;
      trig_seen = 0;
      repeat (12) begin
         @(negedge ref_clk);
         if (on_time_trigger !== 1'b0) trig_seen++;
      end
      switch_cycle_start = 1'b0;
      `CHK("on time pulses", hi ? 0 : 1, trig_seen)
   endtask

   initial begin
      rst = 1'b1;
      gnd = 2'h0;
      programming_mode = 1'b0;
      boot_mode_active = 1'b0;
      offset_strap = 1'b1;
      switch_cycle_start = 1'b0;
      output_above_threshold = 1'b0;
      e_a = {VCD_PSI_RESET, VCD_CODE_RESET};
      e_b = e_a;
      e_n = e_a;
      last_psi = VCD_PSI_RESET;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      step(8'hCE, 8'h85, 18, 2'h0, 1'b0, 1'b0);
      step(8'hD4, 8'h12, 18, 2'h0, 1'b0, 1'b0);
      step(8'hA4, 8'h7F, 18, 2'h0, 1'b0, 1'b0);
      step(8'hC2, 8'h33, 18, 2'h0, 1'b0, 1'b0);
      step(8'hC8, 8'h55, 12, 2'h0, 1'b0, 1'b0);
      step(8'hCC, 8'h21, 18, 2'h1, 1'b0, 1'b0);
      step(8'hC4, 8'hC0, 18, 2'h2, 1'b0, 1'b0);
      step(8'hC4, 8'h01, 18, 2'h0, 1'b1, 1'b0);
      step(8'hC2, 8'h10, 18, 2'h0, 1'b0, 1'b1);
      step(8'hCA, 8'h9A, 18, 2'h0, 1'b0, 1'b0);
      // second reset mid-run with the strap off: codes return, offset stays off
      @(negedge ref_clk);
      rst = 1'b1;
      offset_strap = 1'b0;
      e_a = {VCD_PSI_RESET, VCD_CODE_RESET};
      e_b = e_a;
      e_n = e_a;
      last_psi = VCD_PSI_RESET;
      repeat (12) @(negedge ref_clk);
      `CHK("reset bridge", e_n, bridge_rail)
      rst = 1'b0;
      step(8'hC6, 8'hA5, 18, 2'h0, 1'b0, 1'b0);
      cycle_check(1'b0);
      cycle_check(1'b1);
      tally_and_finish();
   end
endmodule

`default_nettype wire
